//--- src/pfc_pwm_map.svh
// Register offsets, field positions, reset values and timing counts
// for the dual-slope PWM timer. Definitions only, no logic.
`ifndef PFC_PWM_MAP_SVH
`define PFC_PWM_MAP_SVH

// APB byte addresses, one aligned word each
`define OFS_CTRL_A      12'h000
`define OFS_CTRL_B      12'h004
`define OFS_COUNT       12'h008
`define OFS_CMP_A       12'h00C
`define OFS_CMP_B       12'h010
`define OFS_CAPTURE     12'h014
`define OFS_FLAGS       12'h018
`define OFS_PIN_DIR     12'h01C

// Control A fields: out mode A at 7:6, out mode B at 5:4, mode low 1:0
`define CA_MODE_A_HI    7
`define CA_MODE_A_LO    6
`define CA_MODE_B_HI    5
`define CA_MODE_B_LO    4
// Control B fields: mode high 4:3, prescale select 2:0
`define CB_WAVE_HI      4
`define CB_WAVE_LO      3
`define CB_PRE_HI       2
`define CB_PRE_LO       0

// Flag bits
`define FL_OVF          0
`define FL_CMP_A        1
`define FL_CMP_B        2
`define FL_CAP          3

// Waveform modes handled here
`define WAVE_PFC_CAP    4'h8
`define WAVE_PFC_CMPA   4'h9

// Compare output modes
`define OM_OFF          2'h0
`define OM_TOGGLE       2'h1
`define OM_NONINV       2'h2
`define OM_INV          2'h3

// Reset values
`define RST_CTRL        8'h00
`define RST_WORD        16'h0000

// Prescale divisors
`define DIV_8           11'd8
`define DIV_64          11'd64
`define DIV_256         11'd256
`define DIV_1024        11'd1024

`endif

//--- src/pfc_pwm_pkg.sv
// Types shared by the dual-slope PWM timer files.
// Assumes the offsets and fields in pfc_pwm_map.svh.
package pfc_pwm_pkg;

  // Counter direction state, one-hot
  typedef enum logic [1:0] {
    DIR_UP   = 2'b01,
    DIR_DOWN = 2'b10
  } dir_t;

  // Prescale select codes
  typedef enum logic [2:0] {
    PRE_STOP = 3'h0,
    PRE_1    = 3'h1,
    PRE_8    = 3'h2,
    PRE_64   = 3'h3,
    PRE_256  = 3'h4,
    PRE_1024 = 3'h5
  } pre_sel_t;

endpackage : pfc_pwm_pkg

//--- src/tick_prescaler.sv
// Prescaler: produces the one-cycle timer tick used as a clock
// enable. Assumes mclk is the I/O clock and nothing else divides it.
`timescale 1ns/1ps
`include "pfc_pwm_map.svh"
module tick_prescaler #(
  parameter int DIV_W = 11
) (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       nrst,
  // Control
  input  wire logic [2:0] pre_sel,
  // Tick out
  output logic            timer_tick
);

  logic [DIV_W-1:0] div_cnt_r;   // Free divide counter
  logic [DIV_W-1:0] div_lim;     // Divisor for the chosen setting

  // Map select code to divisor; stop yields no tick at all
  always_comb begin
    unique case (pre_sel)
      pfc_pwm_pkg::PRE_8:    div_lim = DIV_W'(`DIV_8);
      pfc_pwm_pkg::PRE_64:   div_lim = DIV_W'(`DIV_64);
      pfc_pwm_pkg::PRE_256:  div_lim = DIV_W'(`DIV_256);
      pfc_pwm_pkg::PRE_1024: div_lim = DIV_W'(`DIV_1024);
      default:               div_lim = DIV_W'(1);
    endcase
  end

  // Divider runs on every edge; tick is an enable, never a clock
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      div_cnt_r <= '0;
    end else if (div_cnt_r >= div_lim - DIV_W'(1)) begin
      div_cnt_r <= '0;
    end else begin
      div_cnt_r <= div_cnt_r + DIV_W'(1);
    end
  end

  // Tick once per divisor period; stopped when select is zero
  assign timer_tick = (pre_sel != 3'h0) &&
                      (pre_sel <= 3'h5) &&
                      (div_cnt_r >= div_lim - DIV_W'(1));

endmodule : tick_prescaler

//--- src/pfc_pwm_timer.sv
// Dual-slope phase-and-frequency-correct PWM timer with APB registers.
// Assumes an APB master on mclk and an external pad that uses
// the output enables.
// Behaviour
// [R1] Modes eight and nine select this operation
// [R2] Count up zero to TOP, back down
// [R3] Non-inverting: clear on up match, set down
// [R4] TOP is capture (8) or compare A (9)
// [R5] Counter holds TOP one tick only
// [R6] Software keeps TOP at least three
// [R7] Compare match sets per-channel flag
// [R8] Bottom loads buffers and sets overflow flag
// [R9] Flag A or capture set at TOP
// [R10] TOP below compare gives no match
// [R11] Mode two normal, three inverted PWM
// [R12] Pin driven only when direction is output
// [R13] Zero gives low, TOP gives high
// [R14] Mode nine, out mode one toggles A
// [R15] Frequency is clock over 2*N*TOP
// [R16] Prefer compare A as changing TOP
// [R17] Bottom-only updates keep slopes symmetrical
// [R18] Prescaled tick is a clock enable
// [R19] Non-zero out mode overrides port pin; B is overridden only in out modes 2 and 3
// [R20] Compare writes buffered until bottom
`timescale 1ns/1ps
`include "pfc_pwm_map.svh"
module pfc_pwm_timer (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        nrst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Compare output pins
  output logic             compare_out_a,
  output logic             compare_out_a_oe,
  output logic             compare_out_b,
  output logic             compare_out_b_oe,
  // Port overrides, high when the timer owns the pin
  output logic             override_a,
  output logic             override_b
);

  // Software-visible registers and internal timer state
  logic [7:0]  timer_control_a_r;  // Out modes and mode low bits
  logic [7:0]  ctrl_b_r;           // Mode high bits and prescale
  logic [15:0] count_value_r;      // The counter
  logic [15:0] buf_a_r;            // Compare A buffer
  logic [15:0] buf_b_r;            // Compare B buffer
  logic [15:0] compare_value_a_r;  // Active compare A
  logic [15:0] compare_value_b_r;  // Active compare B
  logic [15:0] capture_value_r;    // Capture register, TOP in mode 8
  logic [3:0]  flags_r;            // Sticky event flags
  logic [1:0]  pin_dir_r;          // Pin direction bits
  logic        out_a_r;            // Waveform level A
  logic        out_b_r;            // Waveform level B
  pfc_pwm_pkg::dir_t dir_r;        // Count direction

  // Decoded fields
  logic [3:0]  waveform_mode_sel;
  logic [1:0]  out_mode_a;
  logic [1:0]  out_mode_b;
  logic        pfc_mode;
  logic [15:0] top_val;
  logic        timer_tick;
  logic        at_top;
  logic        at_bottom;
  logic        match_a;
  logic        match_b;
  logic        wr_en;
  logic        rd_en;
  logic        addr_ok;
  logic [3:0]  flag_set;
  logic [3:0]  flag_clr;

  // Byte-lane merge of a 16-bit register with write data
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  st);
    merge16 = old;
    if (st[0]) merge16[7:0]  = wd[7:0];
    if (st[1]) merge16[15:8] = wd[15:8];
  endfunction : merge16

  // Next output level on a match for PWM out modes
  function automatic logic pwm_level(input logic [1:0] om,
                                     input logic       up);
    pwm_level = (om == `OM_NONINV) ? ~up : up;  // [R3]
  endfunction : pwm_level

  assign waveform_mode_sel = {ctrl_b_r[`CB_WAVE_HI:`CB_WAVE_LO],
                              timer_control_a_r[1:0]};
  assign out_mode_a = timer_control_a_r[`CA_MODE_A_HI:`CA_MODE_A_LO];
  assign out_mode_b = timer_control_a_r[`CA_MODE_B_HI:`CA_MODE_B_LO];

  // Only modes 8 and 9 run the counter here
  assign pfc_mode = (waveform_mode_sel == `WAVE_PFC_CAP) ||
                    (waveform_mode_sel == `WAVE_PFC_CMPA);  // [R1]

  // TOP source follows the mode selector
  assign top_val = (waveform_mode_sel == `WAVE_PFC_CMPA) ?
                   compare_value_a_r : capture_value_r;  // [R4]

  assign at_top    = (count_value_r == top_val);
  assign at_bottom = (count_value_r == `RST_WORD);
  // Equality only: a compare above TOP never matches
  assign match_a = (count_value_r == compare_value_a_r);  // [R10]
  assign match_b = (count_value_r == compare_value_b_r);  // [R10]

  // Tick generator; counting, flag setting and output levels advance only on its pulse
  tick_prescaler #(
    .DIV_W (11)
  ) u_pre (
    .mclk       (mclk),
    .nrst       (nrst),
    .pre_sel    (ctrl_b_r[`CB_PRE_HI:`CB_PRE_LO]),
    .timer_tick (timer_tick)  // [R18]
  );

  // APB decode; zero-wait answers, error on unmapped words
  assign addr_ok = (paddr[1:0] == 2'h0) && (paddr <= `OFS_PIN_DIR);
  assign wr_en   = psel && penable && pwrite && addr_ok;
  assign rd_en   = psel && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  // Control registers
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      timer_control_a_r <= `RST_CTRL;
      ctrl_b_r          <= `RST_CTRL;
      pin_dir_r         <= 2'h0;
      capture_value_r   <= `RST_WORD;
    end else if (wr_en && pstrb[0]) begin
      unique case (paddr)
        `OFS_CTRL_A:  timer_control_a_r <= pwdata[7:0];
        `OFS_CTRL_B:  ctrl_b_r          <= pwdata[7:0];
        `OFS_PIN_DIR: pin_dir_r         <= pwdata[1:0];
        `OFS_CAPTURE: capture_value_r   <= merge16(capture_value_r,
                                                   pwdata, pstrb);
        default: ;
      endcase
    end else if (wr_en && paddr == `OFS_CAPTURE) begin
      capture_value_r <= merge16(capture_value_r, pwdata, pstrb);
    end
  end

  // Compare buffers take software writes; active values wait
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      buf_a_r <= `RST_WORD;
      buf_b_r <= `RST_WORD;
    end else if (wr_en) begin
      if (paddr == `OFS_CMP_A)
        buf_a_r <= merge16(buf_a_r, pwdata, pstrb);  // [R20]
      if (paddr == `OFS_CMP_B)
        buf_b_r <= merge16(buf_b_r, pwdata, pstrb);  // [R20]
    end
  end

  // Active compare values load only at bottom in this mode
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      compare_value_a_r <= `RST_WORD;
      compare_value_b_r <= `RST_WORD;
    end else if (!pfc_mode) begin
      compare_value_a_r <= buf_a_r;   // Outside this mode: immediate
      compare_value_b_r <= buf_b_r;
    end else if (timer_tick && at_bottom) begin
      compare_value_a_r <= buf_a_r;   // [R8] [R17]
      compare_value_b_r <= buf_b_r;   // [R8] [R17]
    end
  end

  // Counter and direction; TOP is held one tick then turns down
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      count_value_r <= `RST_WORD;
      dir_r         <= pfc_pwm_pkg::DIR_UP;
    end else if (wr_en && paddr == `OFS_COUNT) begin
      count_value_r <= merge16(count_value_r, pwdata, pstrb);
    end else if (pfc_mode && timer_tick) begin
      unique case (dir_r)
        pfc_pwm_pkg::DIR_UP: begin
          if (at_top) begin
            dir_r         <= pfc_pwm_pkg::DIR_DOWN;          // [R5]
            count_value_r <= count_value_r - 16'h0001;       // [R2]
          end else begin
            count_value_r <= count_value_r + 16'h0001;       // [R2]
          end
        end
        pfc_pwm_pkg::DIR_DOWN: begin
          if (at_bottom) begin
            dir_r         <= pfc_pwm_pkg::DIR_UP;
            count_value_r <= count_value_r + 16'h0001;       // [R2]
          end else begin
            count_value_r <= count_value_r - 16'h0001;       // [R2]
          end
        end
        default: dir_r <= pfc_pwm_pkg::DIR_UP;
      endcase
    end
  end
  // Period is 2*TOP ticks, so frequency is clock/(2*N*TOP)  [R15]

  // Flag events, taken on the tick that shows the value
  always_comb begin
    flag_set = 4'h0;
    if (pfc_mode && timer_tick) begin
      flag_set[`FL_OVF]   = at_bottom;                       // [R8]
      flag_set[`FL_CMP_A] = match_a;                         // [R7] [R9]
      flag_set[`FL_CMP_B] = match_b;                         // [R7]
      flag_set[`FL_CAP]   = at_top &&
                            (waveform_mode_sel == `WAVE_PFC_CAP); // [R9]
    end
    flag_clr = (wr_en && paddr == `OFS_FLAGS && pstrb[0]) ?
               pwdata[3:0] : 4'h0;
  end

  // Sticky flags, write one to clear; a set wins over a clear
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      flags_r <= 4'h0;
    end else begin
      flags_r <= (flags_r & ~flag_clr) | flag_set;
    end
  end

  // Waveform levels; bottom counts as up slope so a non-inverting zero compare stays low
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      out_a_r <= 1'b0;
      out_b_r <= 1'b0;
    end else if (pfc_mode && timer_tick) begin
      if (out_mode_a[1] && match_a)
        out_a_r <= pwm_level(out_mode_a, at_bottom ||
                             (dir_r == pfc_pwm_pkg::DIR_UP &&
                              !at_top));                     // [R11] [R13]
      else if (out_mode_a == `OM_TOGGLE && match_a &&
               waveform_mode_sel == `WAVE_PFC_CMPA)
        out_a_r <= ~out_a_r;                                 // [R14]
      if (out_mode_b[1] && match_b)
        out_b_r <= pwm_level(out_mode_b, at_bottom ||
                             (dir_r == pfc_pwm_pkg::DIR_UP &&
                              !at_top));                     // [R11] [R13]
    end
  end

  // Pin override and enable; toggle on B is not a PWM function
  assign override_a = (out_mode_a != `OM_OFF);               // [R19]
  assign override_b = out_mode_b[1];                         // [R19]
  assign compare_out_a    = out_a_r;
  assign compare_out_b    = out_b_r;
  assign compare_out_a_oe = override_a && pin_dir_r[0];      // [R12]
  assign compare_out_b_oe = override_b && pin_dir_r[1];      // [R12]

  // Read mux; read data valid from setup, no side effects
  always_comb begin
    prdata = 32'h0000_0000;
    if (rd_en) begin
      unique case (paddr)
        `OFS_CTRL_A:  prdata = {24'h00_0000, timer_control_a_r};
        `OFS_CTRL_B:  prdata = {24'h00_0000, ctrl_b_r};
        `OFS_COUNT:   prdata = {16'h0000, count_value_r};
        `OFS_CMP_A:   prdata = {16'h0000, buf_a_r};
        `OFS_CMP_B:   prdata = {16'h0000, buf_b_r};
        `OFS_CAPTURE: prdata = {16'h0000, capture_value_r};
        `OFS_FLAGS:   prdata = {28'h000_0000, flags_r};
        `OFS_PIN_DIR: prdata = {30'h0000_0000, pin_dir_r};
        default:      prdata = 32'h0000_0000;
      endcase
    end
  end

  // Helper: ticks spent at TOP in a row
  logic [1:0] top_run_r;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) top_run_r <= 2'h0;
    else if (timer_tick) top_run_r <= (pfc_mode && at_top) ?
                                      top_run_r + 2'h1 : 2'h0;
  end

  property p_top_once;
    @(posedge mclk) disable iff (!nrst) top_run_r < 2'h2;
  endproperty
  a_top_once: assert property (p_top_once) // [R5]
    else $error("counter held TOP more than one tick");

  property p_mode_gate;
    @(posedge mclk) disable iff (!nrst)
      (!pfc_mode && !(wr_en && paddr == `OFS_COUNT)) |=>
      $stable(count_value_r);
  endproperty
  a_mode_gate: assert property (p_mode_gate) // [R1]
    else $error("counter moved outside modes 8 and 9");

  property p_step;
    @(posedge mclk) disable iff (!nrst)
      (pfc_mode && timer_tick && !wr_en && !at_top && !at_bottom) |=>
      (count_value_r == $past(count_value_r) + 16'h0001) ||
      (count_value_r == $past(count_value_r) - 16'h0001);
  endproperty
  a_step: assert property (p_step) // [R2]
    else $error("counter did not step by one");

  property p_top_turn;
    @(posedge mclk) disable iff (!nrst)
      (pfc_mode && timer_tick && at_top && dir_r ==
       pfc_pwm_pkg::DIR_UP && !wr_en) |=> dir_r == pfc_pwm_pkg::DIR_DOWN;
  endproperty
  a_top_turn: assert property (p_top_turn) // [R2]
    else $error("no reversal at TOP");

  property p_match_flag;
    @(posedge mclk) disable iff (!nrst)
      (pfc_mode && timer_tick && match_b) |=> flags_r[`FL_CMP_B];
  endproperty
  a_match_flag: assert property (p_match_flag) // [R7]
    else $error("compare B flag missed");

  property p_bottom_load;
    @(posedge mclk) disable iff (!nrst)
      (pfc_mode && timer_tick && at_bottom) |=>
      flags_r[`FL_OVF] && compare_value_a_r == $past(buf_a_r);
  endproperty
  a_bottom_load: assert property (p_bottom_load) // [R8]
    else $error("bottom load or overflow flag missed");

  property p_cap_flag;
    @(posedge mclk) disable iff (!nrst)
      (timer_tick && at_top && waveform_mode_sel == `WAVE_PFC_CAP) |=>
      flags_r[`FL_CAP];
  endproperty
  a_cap_flag: assert property (p_cap_flag) // [R9]
    else $error("capture flag not set at TOP");

  property p_hold_active;
    @(posedge mclk) disable iff (!nrst)
      (pfc_mode && !(timer_tick && at_bottom)) |=>
      $stable(compare_value_b_r);
  endproperty
  a_hold_active: assert property (p_hold_active) // [R20]
    else $error("active compare changed off bottom");

  property p_pin_gate;
    @(posedge mclk) disable iff (!nrst)
      !pin_dir_r[0] |-> !compare_out_a_oe;
  endproperty
  a_pin_gate: assert property (p_pin_gate) // [R12]
    else $error("pin A driven with direction input");

  property p_up_clear;
    @(posedge mclk) disable iff (!nrst)
      (pfc_mode && timer_tick && match_a && out_mode_a == `OM_NONINV &&
       dir_r == pfc_pwm_pkg::DIR_UP && !at_top) |=> !out_a_r;
  endproperty
  a_up_clear: assert property (p_up_clear) // [R3]
    else $error("output A not cleared on up match");

endmodule : pfc_pwm_timer

//--- sim/test_pfc_pwm_timer.sv
// Self-checking bench for the dual-slope PWM timer: APB register access,
// waveform shapes, flags, buffering and reset. Assumes the timer sits
// alone on mclk and the bench is the only APB master.
`timescale 1ns/1ps
`include "pfc_pwm_map.svh"
module test_pfc_pwm_timer;
  // Clock and reset
  logic        mclk;
  logic        nrst;
  // APB master side
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  // Pins seen from the pad side
  logic        compare_out_a;
  logic        compare_out_a_oe;
  logic        compare_out_b;
  logic        compare_out_b_oe;
  logic        override_a;
  logic        override_b;
  // Bookkeeping
  int          mismatches;
  int          checks;
  int          cyc;
  // One register access and its readback
  typedef struct {
    logic [11:0] a;
    logic [31:0] d;
    logic [3:0]  s;
    logic [31:0] r;
    logic        e;
  } row_t;
  row_t        rows [7];
  logic [31:0] rd;
  logic [31:0] rd2;
  logic        er;
  int          hi;
  int          per;
  int          bad;

  pfc_pwm_timer u_pfc_pwm_timer (
    .mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .compare_out_a(compare_out_a), .compare_out_a_oe(compare_out_a_oe),
    .compare_out_b(compare_out_b), .compare_out_b_oe(compare_out_b_oe),
    .override_a(override_a), .override_b(override_b)
  );

  // 50 MHz clock
  always #10 mclk = ~mclk;

  // Hang guard: the whole run needs well under this many cycles
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      give_verdict();
    end
  end

  // Count a comparison and report a mismatch at once
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // One APB transfer; request held until pready is sampled high
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d,
           input logic [3:0] s, output logic [31:0] r, output logic e);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    // Only the bench timeout ends a wait for the answer
    while (pready !== 1'b1) @(posedge mclk);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'b1, d, 4'hF, rd2, er);
  endtask : wr

  task rdchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0000_0000, 4'h0, rd, er);
    chk(nm, exp, rd);
  endtask : rdchk

  function automatic logic outsig(input int ch);
    return (ch == 0) ? compare_out_a : compare_out_b;
  endfunction : outsig

  // Width of one high pulse and one full period, in clock cycles
  task measure(input int ch, output int h, output int p);
    int n;
    n = 0;
    h = 0;
    p = 0;
    while (outsig(ch) !== 1'b0 && n < 600) begin @(posedge mclk); n++; end
    while (outsig(ch) !== 1'b1 && n < 600) begin @(posedge mclk); n++; end
    while (outsig(ch) === 1'b1 && p < 600) begin
      @(posedge mclk);
      h++;
      p++;
    end
    while (outsig(ch) === 1'b0 && p < 600) begin @(posedge mclk); p++; end
  endtask : measure

  task pwm(input int ch, input int eh, input int ep);
    measure(ch, hi, per);
    chk("pulse high", 32'(eh), 32'(hi));
    chk("period", 32'(ep), 32'(per));
  endtask : pwm

  // Counts of cycles in a window where the output left a constant level
  task steady(input int ch, input logic lvl);
    bad = 0;
    repeat (40) begin
      @(posedge mclk);
      if (outsig(ch) !== lvl) bad++;
    end
    chk("steady level", 32'h0, 32'(bad));
  endtask : steady

  task give_verdict;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict

  initial begin
    mclk = 1'b0; nrst = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; pstrb = 4'h0;
    mismatches = 0; checks = 0; cyc = 0;
    // Rows: address, write data, strobes, readback, error expected
    rows[0] = '{`OFS_CMP_A, 32'h0000_0005, 4'hF, 32'h0000_0005, 1'b0};
    rows[1] = '{`OFS_CMP_B, 32'h0000_AB12, 4'h1, 32'h0000_0012, 1'b0};
    rows[2] = '{`OFS_CMP_B, 32'h0000_0002, 4'h3, 32'h0000_0002, 1'b0};
    rows[3] = '{`OFS_CAPTURE, 32'h0000_0008, 4'hF, 32'h0000_0008, 1'b0};
    rows[4] = '{`OFS_PIN_DIR, 32'h0000_0003, 4'hF, 32'h0000_0003, 1'b0};
    rows[5] = '{`OFS_CTRL_A, 32'h0000_00A0, 4'hF, 32'h0000_00A0, 1'b0};
    rows[6] = '{12'h020, 32'h0000_FFFF, 4'hF, 32'h0000_0000, 1'b1};
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    // Ordinary register accesses, one loop
    foreach (rows[i]) begin
      apb(rows[i].a, 1'b1, rows[i].d, rows[i].s, rd2, er);
      apb(rows[i].a, 1'b0, 32'h0, 4'h0, rd, er);
      chk("readback", rows[i].r, rd);
      chk("slave error", {31'h0, rows[i].e}, {31'h0, er});
    end
    chk("override a", 32'h1, {31'h0, override_a});
    chk("override b", 32'h1, {31'h0, override_b});
    // Reset in mid-run clears every register and output
    @(posedge mclk);
    nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    for (int k = 0; k < 8; k++) rdchk("reset value", 12'(4 * k), 32'h0);
    chk("reset pins", 32'h0, {26'h0, compare_out_a, compare_out_a_oe,
        compare_out_b, compare_out_b_oe, override_a, override_b});
    // Mode 8, TOP from capture, both channels non-inverting
    wr(`OFS_CMP_A, 32'h5);
    wr(`OFS_CMP_B, 32'h2);
    wr(`OFS_CAPTURE, 32'h8);
    wr(`OFS_PIN_DIR, 32'h2);
    wr(`OFS_CTRL_A, 32'hA0);
    wr(`OFS_CTRL_B, 32'h11);
    pwm(0, 10, 16);
    pwm(1, 4, 16);
    chk("oe a", 32'h0, {31'h0, compare_out_a_oe});
    chk("oe b", 32'h1, {31'h0, compare_out_b_oe});
    // Flags: overflow, both matches and capture at TOP
    wr(`OFS_FLAGS, 32'hF);
    repeat (20) @(posedge mclk);
    rdchk("flags", `OFS_FLAGS, 32'hF);
    // Compare B above TOP never matches
    wr(`OFS_CMP_B, 32'hA);
    repeat (20) @(posedge mclk);
    wr(`OFS_FLAGS, 32'hF);
    repeat (20) @(posedge mclk);
    rdchk("flags no b", `OFS_FLAGS, 32'hB);
    // Inverted A, prescale by 8
    wr(`OFS_CMP_B, 32'h2);
    wr(`OFS_CTRL_A, 32'hE0);
    pwm(0, 6, 16);
    wr(`OFS_CTRL_B, 32'h12);
    pwm(0, 48, 128);
    // Extremes: zero holds low, TOP holds high
    wr(`OFS_CTRL_B, 32'h11);
    wr(`OFS_CTRL_A, 32'hA0);
    wr(`OFS_CMP_A, 32'h0);
    wr(`OFS_CMP_B, 32'h8);
    // A new zero compare needs one bottom to load and another to act on it
    repeat (40) @(posedge mclk);
    steady(0, 1'b0);
    steady(1, 1'b1);
    // Compare writes at several phases only land at the bottom; wait
    // out that bottom so the measured pulse and period are whole
    for (int k = 0; k < 4; k++) begin
      wr(`OFS_CMP_A, (k % 2) ? 32'h5 : 32'h3);
      repeat (k * 3 + 17) @(posedge mclk);
      measure(0, hi, per);
      chk("whole pulse", (k % 2) ? 32'd10 : 32'd6, 32'(hi));
      chk("period", 32'd16, 32'(per));
    end
    // Mode 9, TOP from compare A, out mode 1 toggles A; the new TOP
    // must be active before the switch or the count runs past it
    wr(`OFS_CMP_A, 32'h8);
    repeat (16) @(posedge mclk);
    wr(`OFS_PIN_DIR, 32'h1);
    wr(`OFS_CTRL_A, 32'h41);
    pwm(0, 16, 32);
    chk("override a", 32'h1, {31'h0, override_a});
    chk("override b", 32'h0, {31'h0, override_b});
    chk("oe a", 32'h1, {31'h0, compare_out_a_oe});
    // Mode 0 is outside this block: the counter stands still
    wr(`OFS_CTRL_A, 32'hA0);
    wr(`OFS_CTRL_B, 32'h01);
    apb(`OFS_COUNT, 1'b0, 32'h0, 4'h0, rd, er);
    repeat (10) @(posedge mclk);
    rdchk("count frozen", `OFS_COUNT, rd);
    give_verdict();
  end
endmodule : test_pfc_pwm_timer
